// ==== core/ccmc_config_regs.sv ====
/*
 * Configuration register bank of the communication controller: mode bits,
 * channel enables, guardian monitor options, error-level permissions and
 * pad drive and pull settings, with a minimal error-level state.
 * Assumes an AHB-Lite master on one clock; protocol engine outside.
 * Bus and event inputs are taken as synchronous to clk.
 * Pull direction, timing and regulator registers are not in this bank.
 */
// The AHB-Lite register port was left to the implementer.
// Operation
// RL1 - Sync filter on: only filter-passing sync frames feed clock sync
// RL2 - Channel A enable, writable only in configuration state
// RL3 - Channel B enable, writable only in configuration state
// RL4 - Setting config bit enters config state, aborts traffic, drops sync; here syncFrameUse is not gated by config state
// RL5 - Clearing config bit resumes normal operation
// RL6 - After reset controller is in config state, bit reads set
// RL7 - Media access test enable, writable only in config state
// RL8 - Guardian expected open in symbol window when bit set; config-only write
// RL9 - Guardian expected open in dynamic segment when bit set; config-only write
// RL10 - External clock sync enable, writable only in config state
// RL11 - Coldstart inhibit blocks schedule start; config-only write
// RL12 - Clock sync error: red level if allowed, else config state
// RL13 - Yellow to green return only when permitted
// RL14 - Host pin drive bits: 1 partial, 0 full
// RL15 - Phy pin drive bits: 1 partial, 0 full
// RL16 - Host pin pull enable bits; direction held elsewhere
// RL17 - Write setting config bit changes only that bit
// RL18 - Config-only writes ignored outside config; reserved read zero
// RL19 - Pad registers reset to zero and drive pad outputs
`timescale 1ns/1ns
module ccmc_config_regs
	import ccmc_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	// AHB-Lite register bus
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic [31:0]               hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	// Protocol engine events and settings
	input  wire logic                 syncFrameValid,
	input  wire logic                 syncAcceptPass,
	input  wire logic                 syncRejectHit,
	input  wire logic                 clockSyncError,
	input  wire logic                 yellowRecovered,
	input  wire logic                 enterYellow,
	output logic                      syncFrameUse,
	output logic                      configState,
	output logic                      abortTraffic,
	output logic                      chanAEnable,
	output logic                      chanBEnable,
	output logic                      mediaAccessTestEnable,
	output logic                      guardianSymwinOpen,
	output logic                      guardianDynsegOpen,
	output logic                      extClockSyncEnable,
	output logic                      coldstartAllowed,
	output logic                      diagStop,
	output ccmc_pkg::ccmc_err_level_e errLevel,
	// Pad controls
	output logic [5:0]                hostPinPartialDrive,
	output logic [3:0]                phyPinPartialDrive,
	output logic [15:0]               hostPinPullEnable
);
	logic [15:0]      cfgZero_q;
	logic [15:0]      cfgZero_d;
	logic [15:0]      cfgOne_q;
	logic [15:0]      cfgOne_d;
	logic [15:0]      hostDrive_q;
	logic [15:0]      phyDrive_q;
	logic [15:0]      hostPull_q;
	logic             wrPend_q;
	logic [9:0]       wrAddr_q;
	logic             diag_q;
	logic             diag_d;
	ccmc_err_level_e  errLevel_q;
	ccmc_err_level_e  errLevel_d;
	logic             inConfig;
	logic             addrTake;
	logic [31:0]      rdMux;
	logic [15:0]      wdata;
	logic             wrZero;
	logic             wrOne;
	logic             wrHostDrive;
	logic             wrPhyDrive;
	logic             wrHostPull;
	logic             syncFilterOn;
	logic             syncFramePass;
	logic             redAllowed;
	logic             cfgForce;

	assign inConfig = cfgZero_q[CFG_STATE_BIT];
	assign addrTake = hsel && hready && htrans == HTRANS_NONSEQ;
	assign wdata    = hwdata[15:0];

	// One strobe per register, in the data phase of a word write
	assign wrZero      = wrPend_q && wrAddr_q == ADDR_MODULE_CONFIG_ZERO;
	assign wrOne       = wrPend_q && wrAddr_q == ADDR_MODULE_CONFIG_ONE;
	assign wrHostDrive = wrPend_q && wrAddr_q == ADDR_HOST_PIN_DRIVE;
	assign wrPhyDrive  = wrPend_q && wrAddr_q == ADDR_PHY_PIN_DRIVE;
	assign wrHostPull  = wrPend_q && wrAddr_q == ADDR_HOST_PIN_PULL_ENABLE;

	// Filters gate sync frames only while the enable bit is set
	assign syncFilterOn  = cfgZero_q[SYNC_FILTER_ENABLE_BIT];
	assign syncFramePass = syncAcceptPass && !syncRejectHit;

	// Sync error without red permission falls back to configuration
	assign redAllowed = cfgOne_q[ALLOW_RED_LEVEL_BIT];
	assign cfgForce   = clockSyncError && !redAllowed && !inConfig;

	// Zero-wait slave: always ready, always OKAY
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			hreadyout <= 1'b1;
		else
			hreadyout <= 1'b1;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			hresp <= 1'b0;
		else
			hresp <= 1'b0;
	end

	// Write address captured in the address phase, data used next cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			wrPend_q <= 1'b0;
		else
			wrPend_q <= addrTake && hwrite && hsize == HSIZE_WORD;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			wrAddr_q <= 10'h000;
		else if (addrTake)
			wrAddr_q <= haddr[9:0];
	end

	// Reserved bits read zero; unmapped words read zero
	always_comb
	begin
		rdMux = 32'h00000000;
		unique case (haddr[9:0])
			ADDR_MODULE_CONFIG_ZERO:   rdMux[15:0] = cfgZero_q; // see RL18
			ADDR_MODULE_CONFIG_ONE:    rdMux[15:0] = cfgOne_q;
			ADDR_HOST_PIN_DRIVE:       rdMux[15:0] = hostDrive_q;
			ADDR_PHY_PIN_DRIVE:        rdMux[15:0] = phyDrive_q;
			ADDR_HOST_PIN_PULL_ENABLE: rdMux[15:0] = hostPull_q;
			default:                   rdMux = 32'h00000000;
		endcase
	end

	// Read data registered at the address phase, valid in the data phase
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			hrdata <= 32'h00000000;
		else if (addrTake && !hwrite)
			hrdata <= rdMux;
	end

	// Setting the config bit wins alone; clearing may carry other fields
	always_comb
	begin
		cfgZero_d = cfgZero_q;
		if (!inConfig && wdata[CFG_STATE_BIT])
			cfgZero_d[CFG_STATE_BIT] = 1'b1; // see RL4 see RL17
		else
		begin
			cfgZero_d = (cfgZero_q & ~ZERO_ANYTIME_MASK) | (wdata & ZERO_ANYTIME_MASK);
			if (inConfig)
				cfgZero_d = (cfgZero_d & ~ZERO_CFG_ONLY_MASK)
					| (wdata & ZERO_CFG_ONLY_MASK); // see RL2 see RL3 see RL18
			cfgZero_d[CFG_STATE_BIT] = wdata[CFG_STATE_BIT]; // see RL5
		end
	end

	// Hardware fallback beats a host write in the same cycle
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			cfgZero_q <= MODULE_CONFIG_ZERO_RESET; // see RL6
		else if (cfgForce)
			cfgZero_q[CFG_STATE_BIT] <= 1'b1; // see RL12
		else if (wrZero)
			cfgZero_q <= cfgZero_d;
	end

	// Whole register is configuration-only
	always_comb
	begin
		cfgOne_d = cfgOne_q;
		if (wrOne && inConfig)
			cfgOne_d = wdata & ONE_CFG_ONLY_MASK; // see RL7 see RL10 see RL18
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			cfgOne_q <= MODULE_CONFIG_ONE_RESET;
		else
			cfgOne_q <= cfgOne_d;
	end

	// Pad registers: reserved bits masked off on write
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			hostDrive_q <= PAD_REG_RESET; // see RL19
		else if (wrHostDrive)
			hostDrive_q <= wdata & HOST_DRIVE_MASK; // see RL14
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			phyDrive_q <= PAD_REG_RESET;
		else if (wrPhyDrive)
			phyDrive_q <= wdata & PHY_DRIVE_MASK; // see RL15
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			hostPull_q <= PAD_REG_RESET;
		else if (wrHostPull)
			hostPull_q <= wdata & HOST_PULL_MASK; // see RL16
	end

	// Error level: red only if allowed, yellow back to green if permitted
	always_comb
	begin
		errLevel_d = errLevel_q;
		if (inConfig)
			errLevel_d = CCMC_ERR_GREEN;
		else if (clockSyncError && redAllowed)
			errLevel_d = CCMC_ERR_RED; // see RL12
		else
		begin
			unique case (errLevel_q)
				CCMC_ERR_GREEN:
					if (enterYellow)
						errLevel_d = CCMC_ERR_YELLOW;
				CCMC_ERR_YELLOW:
					if (yellowRecovered && cfgOne_q[ALLOW_YELLOW_TO_GREEN_BIT])
						errLevel_d = CCMC_ERR_GREEN; // see RL13
				CCMC_ERR_RED:
					errLevel_d = CCMC_ERR_RED;
				default:
					errLevel_d = CCMC_ERR_GREEN;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			errLevel_q <= CCMC_ERR_GREEN;
		else
			errLevel_q <= errLevel_d;
	end

	// Diagnosis stop: only entering config leaves it
	always_comb
	begin
		diag_d = diag_q;
		if (inConfig)
			diag_d = 1'b0;
		else if (clockSyncError && redAllowed)
			diag_d = 1'b1; // see RL12
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			diag_q <= 1'b0;
		else
			diag_q <= diag_d;
	end

	// Sync frame gate, one cycle after the frame
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			syncFrameUse <= 1'b0;
		else
			syncFrameUse <= syncFrameValid && (!syncFilterOn || syncFramePass); // see RL1
	end

	// Mode outputs; channels and coldstart held off in config
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			configState      <= 1'b1;
			abortTraffic     <= 1'b1;
			chanAEnable      <= 1'b0;
			chanBEnable      <= 1'b0;
			coldstartAllowed <= 1'b0;
		end
		else
		begin
			configState      <= inConfig;
			abortTraffic     <= inConfig; // see RL4
			chanAEnable      <= cfgZero_q[CHAN_A_ENABLE_BIT] && !inConfig; // see RL2
			chanBEnable      <= cfgZero_q[CHAN_B_ENABLE_BIT] && !inConfig; // see RL3
			coldstartAllowed <= !cfgOne_q[COLDSTART_INHIBIT_BIT] && !inConfig; // see RL11
		end
	end

	// Guardian monitor and clock sync option copies
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mediaAccessTestEnable <= 1'b0;
			guardianSymwinOpen    <= 1'b0;
			guardianDynsegOpen    <= 1'b0;
			extClockSyncEnable    <= 1'b0;
		end
		else
		begin
			mediaAccessTestEnable <= cfgOne_q[MEDIA_ACCESS_TEST_BIT]; // see RL7
			guardianSymwinOpen    <= cfgOne_q[GUARDIAN_SYMWIN_OPEN_BIT]; // see RL8
			guardianDynsegOpen    <= cfgOne_q[GUARDIAN_DYNSEG_OPEN_BIT]; // see RL9
			extClockSyncEnable    <= cfgOne_q[EXT_CLOCK_SYNC_ENABLE_BIT]; // see RL10
		end
	end

	// Error handling level outputs
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			diagStop <= 1'b0;
			errLevel <= CCMC_ERR_GREEN;
		end
		else
		begin
			diagStop <= diag_q;
			errLevel <= errLevel_q;
		end
	end

	// Pad controls follow the pad registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			hostPinPartialDrive <= 6'h00;
			phyPinPartialDrive  <= 4'h0;
			hostPinPullEnable   <= 16'h0000;
		end
		else
		begin
			hostPinPartialDrive <= hostDrive_q[5:0]; // see RL19
			phyPinPartialDrive  <= phyDrive_q[3:0];
			hostPinPullEnable   <= hostPull_q;
		end
	end
endmodule

// ==== common/ccmc_pkg.sv ====
/*
 * Package for the controller configuration register bank: byte addresses,
 * field positions, write masks and reset values.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package ccmc_pkg;
	// Printed offsets are not all multiples of four: they are indexes
	localparam logic [7:0]  IDX_MODULE_CONFIG_ZERO     = 8'h04;
	localparam logic [7:0]  IDX_MODULE_CONFIG_ONE      = 8'h06;
	localparam logic [7:0]  IDX_HOST_PIN_DRIVE         = 8'h9a;
	localparam logic [7:0]  IDX_PHY_PIN_DRIVE          = 8'h9c;
	localparam logic [7:0]  IDX_HOST_PIN_PULL_ENABLE   = 8'h9e;
	localparam logic [9:0]  ADDR_MODULE_CONFIG_ZERO    = {IDX_MODULE_CONFIG_ZERO, 2'b00};
	localparam logic [9:0]  ADDR_MODULE_CONFIG_ONE     = {IDX_MODULE_CONFIG_ONE, 2'b00};
	localparam logic [9:0]  ADDR_HOST_PIN_DRIVE        = {IDX_HOST_PIN_DRIVE, 2'b00};
	localparam logic [9:0]  ADDR_PHY_PIN_DRIVE         = {IDX_PHY_PIN_DRIVE, 2'b00};
	localparam logic [9:0]  ADDR_HOST_PIN_PULL_ENABLE  = {IDX_HOST_PIN_PULL_ENABLE, 2'b00};

	// module_config_zero fields
	localparam int          CFG_STATE_BIT              = 15;
	localparam int          CHAN_B_ENABLE_BIT          = 9;
	localparam int          CHAN_A_ENABLE_BIT          = 8;
	localparam int          SYNC_FILTER_ENABLE_BIT     = 6;
	localparam logic [15:0] ZERO_CFG_ONLY_MASK         = 16'h0300;
	localparam logic [15:0] ZERO_ANYTIME_MASK          = 16'h0040;
	localparam logic [15:0] MODULE_CONFIG_ZERO_RESET   = 16'h8000;

	// module_config_one fields
	localparam int          ALLOW_YELLOW_TO_GREEN_BIT  = 10;
	localparam int          ALLOW_RED_LEVEL_BIT        = 9;
	localparam int          COLDSTART_INHIBIT_BIT      = 8;
	localparam int          EXT_CLOCK_SYNC_ENABLE_BIT  = 6;
	localparam int          GUARDIAN_DYNSEG_OPEN_BIT   = 5;
	localparam int          GUARDIAN_SYMWIN_OPEN_BIT   = 4;
	localparam int          MEDIA_ACCESS_TEST_BIT      = 2;
	localparam logic [15:0] ONE_CFG_ONLY_MASK          = 16'h0774;
	localparam logic [15:0] MODULE_CONFIG_ONE_RESET    = 16'h0000;

	// Pad control registers
	localparam logic [15:0] HOST_DRIVE_MASK            = 16'h003f;
	localparam logic [15:0] PHY_DRIVE_MASK             = 16'h000f;
	localparam logic [15:0] HOST_PULL_MASK             = 16'hffff;
	localparam logic [15:0] PAD_REG_RESET              = 16'h0000;

	localparam logic [1:0]  HTRANS_NONSEQ              = 2'b10;
	localparam logic [2:0]  HSIZE_WORD                 = 3'b010;

	typedef enum logic [1:0] {
		CCMC_ERR_GREEN  = 2'b00,
		CCMC_ERR_YELLOW = 2'b01,
		CCMC_ERR_RED    = 2'b11
	} ccmc_err_level_e;
endpackage

// ==== tb/ccmc_config_monitor.sv ====
/* Assertions on the ports of the configuration register bank.
   Assumes one clock and the asynchronous active-low reset. */
`timescale 1ns/1ns
module ccmc_config_monitor
	import ccmc_pkg::*;
(
	input wire logic                     clk,
	input wire logic                     reset_n,
	input wire logic                     hreadyout,
	input wire logic                     hresp,
	input wire logic                     syncFrameValid,
	input wire logic                     syncAcceptPass,
	input wire logic                     syncRejectHit,
	input wire logic                     syncFrameUse,
	input wire logic                     clockSyncError,
	input wire logic                     configState,
	input wire logic                     abortTraffic,
	input wire logic                     chanAEnable,
	input wire logic                     coldstartAllowed,
	input wire logic                     diagStop,
	input wire ccmc_pkg::ccmc_err_level_e errLevel
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	sequence passFrame;
		syncFrameValid && syncAcceptPass && !syncRejectHit;
	endsequence
	// Two cycles covers the one-cycle lag of derived outputs
	sequence cfgHeld;
		configState [*2];
	endsequence
	okay_resp_a: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	cfg_start_a: assert property ($rose(reset_n) |-> configState)
		else $error("not in config after reset");
	abort_tracks_a: assert property (abortTraffic == configState)
		else $error("abort differs from config state");
	chan_off_a: assert property (cfgHeld |-> !chanAEnable)
		else $error("channel on in config state");
	coldstart_off_a: assert property (cfgHeld |-> !coldstartAllowed)
		else $error("coldstart allowed in config state");
	frame_used_a: assert property (passFrame |=> syncFrameUse)
		else $error("passing frame not used");
	use_cause_a: assert property (syncFrameUse |-> $past(syncFrameValid))
		else $error("frame use without frame");
	red_diag_a: assert property (diagStop == (errLevel == CCMC_ERR_RED))
		else $error("diag stop differs from red level");
	sync_err_a: assert property (clockSyncError |-> ##[1:3] (configState || diagStop))
		else $error("sync error not handled");
endmodule
bind ccmc_config_regs ccmc_config_monitor ccmc_config_monitor_inst (.clk(clk),
	.reset_n(reset_n), .hreadyout(hreadyout), .hresp(hresp),
	.syncFrameValid(syncFrameValid), .syncAcceptPass(syncAcceptPass),
	.syncRejectHit(syncRejectHit), .syncFrameUse(syncFrameUse),
	.clockSyncError(clockSyncError), .configState(configState),
	.abortTraffic(abortTraffic), .chanAEnable(chanAEnable),
	.coldstartAllowed(coldstartAllowed), .diagStop(diagStop), .errLevel(errLevel));

// ==== tb/ccmc_ahb_host.sv ====
/* Host model: single-word AHB-Lite master with one access task.
   Assumes hready is the one slave's hreadyout. */
`timescale 1ns/1ns
module ccmc_ahb_host
	import ccmc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel = 1'b0,
	output logic [31:0]      haddr = 32'h0,
	output logic [1:0]       htrans = 2'h0,
	output logic             hwrite = 1'b0,
	output logic [2:0]       hsize = HSIZE_WORD,
	output logic [31:0]      hwdata = 32'h0
);
	bit stuck = 0;
	// Bounded so a dead slave sets stuck and the run goes on instead of hanging
	task automatic waitReady();
		int i;
		i = 0;
		do
		begin
			@(posedge clk);
			i++;
		end
		while (!hready && i < 16);
		if (!hready)
			stuck = 1;
	endtask
	task automatic access(input logic [9:0] a, input logic wr, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {22'h0, a};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		waitReady();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		waitReady();
		q = hrdata;
	endtask
endmodule

// ==== tb/testbench.sv ====
/* Self-checking bench of the configuration register bank.
   Assumes the host model for bus cycles; side inputs driven here. */
`timescale 1ns/1ns
module testbench;
	import ccmc_pkg::*;
	logic clk = 0, reset_n = 0, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic frmValid = 0, frmPass = 0, frmRej = 0, syncErr = 0, yelRec = 0, yelIn = 0;
	logic use_, cfg, abrt, chA, chB, mat, sym, dyn, ecs, cold, diag;
	ccmc_err_level_e lvl;
	logic [5:0] hd;
	logic [3:0] pd;
	logic [15:0] pu;
	int n_errors = 0, cmp_count = 0;
	logic [9:0] padA[3] = '{ADDR_HOST_PIN_DRIVE, ADDR_PHY_PIN_DRIVE, ADDR_HOST_PIN_PULL_ENABLE};
	logic [15:0] padM[3] = '{HOST_DRIVE_MASK, PHY_DRIVE_MASK, HOST_PULL_MASK};
	localparam logic [9:0] Z = ADDR_MODULE_CONFIG_ZERO, O = ADDR_MODULE_CONFIG_ONE;
	always #10 clk = ~clk;
	ccmc_ahb_host ccmc_ahb_host_inst (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata));
	ccmc_config_regs ccmc_config_regs_inst (.clk(clk), .reset_n(reset_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.syncFrameValid(frmValid), .syncAcceptPass(frmPass), .syncRejectHit(frmRej),
		.clockSyncError(syncErr), .yellowRecovered(yelRec), .enterYellow(yelIn),
		.syncFrameUse(use_), .configState(cfg), .abortTraffic(abrt), .chanAEnable(chA),
		.chanBEnable(chB), .mediaAccessTestEnable(mat), .guardianSymwinOpen(sym),
		.guardianDynsegOpen(dyn), .extClockSyncEnable(ecs), .coldstartAllowed(cold),
		.diagStop(diag), .errLevel(lvl), .hostPinPartialDrive(hd),
		.phyPinPartialDrive(pd), .hostPinPullEnable(pu));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		if (ccmc_ahb_host_inst.stuck)
			n_errors++;
		$display("mismatches %0d comparisons %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		ccmc_ahb_host_inst.access(a, 1'b1, d, q);
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] exp);
		ccmc_ahb_host_inst.access(a, 1'b0, 32'h0, q);
		chk("register", q, exp);
	endtask
	// Derived outputs lag the register by one cycle
	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic evt(input logic [2:0] v);
		@(posedge clk);
		{yelIn, yelRec, syncErr} <= v;
		@(posedge clk);
		{yelIn, yelRec, syncErr} <= 3'h0;
		settle();
	endtask
	task automatic frame(input logic a, input logic r, input logic exp);
		@(posedge clk);
		{frmValid, frmPass, frmRej} <= {1'b1, a, r};
		@(posedge clk);
		frmValid <= 1'b0;
		#1;
		chk("frame use", {31'h0, use_}, {31'h0, exp});
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rd(Z, 32'h8000);
		rd(O, 32'h0);
		foreach (padA[i])
		begin
			rd(padA[i], 32'h0);
			wr(padA[i], 32'hffffffff);
			rd(padA[i], {16'h0, padM[i]});
		end
		settle();
		chk("pads", 32'({hd, pd, pu}),
			32'({HOST_DRIVE_MASK[5:0], PHY_DRIVE_MASK[3:0], HOST_PULL_MASK}));
		wr(10'h3fc, 32'hffffffff);
		rd(10'h3fc, 32'h0);
		wr(Z, 32'hffffffff);
		rd(Z, 32'h8340);
		wr(O, 32'hffffffff);
		rd(O, 32'h0774);
		settle();
		chk("cfg one", 32'({mat, sym, dyn, ecs, cold}), 32'(5'b11110));
		wr(Z, 32'h0340);
		rd(Z, 32'h0340);
		settle();
		chk("mode", 32'({cfg, abrt, chA, chB, cold}), 32'(5'b00110));
		wr(O, 32'h0);
		rd(O, 32'h0774);
		wr(Z, 32'h0);
		rd(Z, 32'h0300);
		evt(3'b100);
		chk("level", 32'(lvl), 32'(CCMC_ERR_YELLOW));
		evt(3'b010);
		chk("level", 32'(lvl), 32'(CCMC_ERR_GREEN));
		evt(3'b001);
		chk("red", 32'({lvl, diag}), 32'({CCMC_ERR_RED, 1'b1}));
		wr(Z, 32'h8040);
		rd(Z, 32'h8300);
		settle();
		chk("enter", 32'({cfg, abrt, chA, diag}), 32'(4'b1100));
		wr(O, 32'h0);
		wr(Z, 32'h0);
		settle();
		chk("cold", 32'(cold), 32'(1'b1));
		evt(3'b100);
		evt(3'b010);
		chk("level", 32'(lvl), 32'(CCMC_ERR_YELLOW));
		evt(3'b001);
		chk("cfg", 32'(cfg), 32'(1'b1));
		frame(1'b0, 1'b1, 1'b1);
		wr(Z, 32'h0040);
		frame(1'b0, 1'b0, 1'b0);
		frame(1'b1, 1'b1, 1'b0);
		frame(1'b1, 1'b0, 1'b1);
		conclude();
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		conclude();
	end
endmodule
